// ---- csif_unit.v ----
// Context-state and interrupt-flag unit with APB register access
// Summary of operation
// - Second vector logic usable only while its enable field is set.
// - Any set flag raises the swap request; flag word stored with context.
// - Flags still set after a context load cause an immediate new swap.
// - Cross-processor interrupt from another processor sets its flag.
// - All processors of our cluster holding on test-and-set sets deadlock flag.
// - Programmable clock countdown reaching zero sets its flag.
// - Master I/O processor interrupt signal sets its flag.
// - Floating range error sets flag when float interrupt mode enabled.
// - Operand out of data bounds sets flag when operand mode enabled.
// - Instruction fetch outside instruction bounds sets flag unless in supervisor mode.
// - Memory error sets flag when that error class is enabled.
// - Channel transfer completion sets the I/O flag.
// - Error exit outside supervisor mode sets error-exit flag.
// - Normal exit outside both supervisor modes sets normal-exit flag.
// - Context address is 8 upper bits of 12-bit word address.
// - End of interval swaps registers with block at context address.
// - Vector length field gives element count of vector work.
// - Address extension applies only when extended addressing is set.
// - Operand allowed only if address at least data base.
// - Operand allowed only if address below data limit.
// - Operand outside data window raises operand range error condition.
// - Cluster number selects shared register set; zero denies all.
// - Instruction fetch allowed only at or above instruction base.
// - Supervisor mode blocks all interrupts but memory errors, exits included.
`timescale 1ns/1ps
`default_nettype none
`include "csif_consts.vh"
module csif_unit #(
  parameter NCPU = 4
) (
  input  wire                    pclk,
  input  wire                    presetn,
  // APB slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [11:0]             paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  // Event sources
  input  wire                    xcpu_int,
  input  wire [NCPU-1:0]         peer_ts_hold,
  input  wire [NCPU*`CSIF_CL_W-1:0] peer_cluster,
  input  wire                    own_ts_hold,
  input  wire                    pclk_count_zero,
  input  wire                    master_io_processor,
  input  wire                    float_range_err,
  input  wire                    corr_mem_err,
  input  wire                    uncorr_mem_err,
  input  wire                    channel_done,
  input  wire                    error_exit_exec,
  input  wire                    normal_exit_exec,
  // Address checks
  input  wire                    operand_req,
  input  wire [`CSIF_AW-1:0]     operand_addr,
  input  wire                    fetch_req,
  input  wire [`CSIF_AW-1:0]     fetch_addr,
  // Context swap handshake with the issue logic
  input  wire                    interval_end,
  input  wire                    swap_done,
  input  wire [`CSIF_NFLAGS-1:0] load_flags,
  input  wire [`CSIF_NMODE-1:0]  load_mode,
  input  wire [`CSIF_XA_W-1:0]   load_xa,
  input  wire [`CSIF_VL_W-1:0]   load_vl,
  input  wire [`CSIF_AW-1:0]     load_dba,
  input  wire [`CSIF_AW-1:0]     load_dla,
  input  wire [`CSIF_AW-1:0]     load_iba,
  input  wire [`CSIF_AW-1:0]     load_ila,
  input  wire [`CSIF_CL_W-1:0]   load_cluster,
  input  wire [`CSIF_PS_W-1:0]   load_ps,
  input  wire                    load_svl,
  input  wire                    load_eam,
  output wire                    request_interrupt,
  output reg                     swap_active,
  output wire [11:0]             swap_word_addr,
  output wire [`CSIF_NFLAGS-1:0] store_flags,
  output wire [`CSIF_PS_W-1:0]   store_ps,
  // Context fields toward the datapath
  output wire                    second_vlogic_enable,
  output wire [`CSIF_VL_W-1:0]   vector_length,
  output wire                    extended_addressing,
  output wire [`CSIF_CL_W-1:0]   cluster_number,
  output wire                    shared_access_ok,
  output wire                    operand_ok,
  output wire                    fetch_ok
);

  //////////////////////////////////////////////////////////////////////
  // Context state
  // Only the fields this unit acts on are held here; address and scalar
  // registers are moved by the issue logic during the swap itself.
  reg [`CSIF_NFLAGS-1:0] flags_r;
  reg [`CSIF_NMODE-1:0]  mode_r;
  reg [`CSIF_XA_W-1:0]   xa_r;
  reg [`CSIF_VL_W-1:0]   vl_r;
  reg [`CSIF_AW-1:0]     dba_r;
  reg [`CSIF_AW-1:0]     dla_r;
  reg [`CSIF_AW-1:0]     iba_r;
  reg [`CSIF_AW-1:0]     ila_r;
  reg [`CSIF_CL_W-1:0]   cl_r;
  reg [`CSIF_PS_W-1:0]   ps_r;
  reg                    svl_r;
  reg                    eam_r;
  reg [`CSIF_NFLAGS-1:0] flags_nxt;
  reg [`CSIF_NFLAGS-1:0] ev;

  wire op_lo;
  wire op_hi;
  wire op_in;
  wire fe_lo;
  wire fe_in;
  wire sup;
  wire supervisor_interrupt_mode;
  wire deadlock;

  //////////////////////////////////////////////////////////////////////
  // Bounds checkers
  csif_bounds u_opchk (
    .addr     (operand_addr),
    .base     (dba_r),
    .limit    (dla_r),
    .lo_ok    (op_lo),
    .hi_ok    (op_hi),
    .in_range (op_in)
  );

  csif_bounds u_fechk (
    .addr     (fetch_addr),
    .base     (iba_r),
    .limit    (ila_r),
    .lo_ok    (fe_lo),
    .hi_ok    (),
    .in_range (fe_in)
  );

  // Operand permission needs both bounds
  assign operand_ok = op_lo & op_hi;
  // Fetch permission checked at buffer fetch time
  assign fetch_ok   = fe_lo & fe_in;

  //////////////////////////////////////////////////////////////////////
  // Deadlock: every peer sharing our nonzero cluster holds on test-and-set
  wire [NCPU-1:0] peer_blocks;
  genvar gi;
  generate
    for (gi = 0; gi < NCPU; gi = gi + 1) begin : g_peer
      // A peer in another cluster cannot hold ours back
      assign peer_blocks[gi] =
        (peer_cluster[gi*`CSIF_CL_W +: `CSIF_CL_W] != cl_r) | peer_ts_hold[gi];
    end
  endgenerate
  // A zero cluster never deadlocks: such a processor shares nothing
  assign deadlock = own_ts_hold & (cl_r != {`CSIF_CL_W{1'b0}}) & (&peer_blocks);

  //////////////////////////////////////////////////////////////////////
  // Event gating; supervisor mode passes only memory errors
  // Events are level sensitive: a source held high keeps re-setting its
  // flag, so it must drop before the swap completes or the swap repeats.
  // Exit events are masked in supervisor mode by their own flag rules,
  // so in practice only memory errors pass the supervisor gate.
  assign sup = mode_r[`CSIF_M_MM];
  assign supervisor_interrupt_mode = mode_r[`CSIF_M_IMM];
  always @* begin
    ev = {`CSIF_NFLAGS{1'b0}};
    ev[`CSIF_F_XCPU] = xcpu_int & ~sup;
    ev[`CSIF_F_DEAD] = deadlock & ~sup;
    ev[`CSIF_F_PCLK] = pclk_count_zero & ~sup;
    ev[`CSIF_F_MASTER_IO_PROCESSOR] = master_io_processor & ~sup;
    ev[`CSIF_F_FPE]  = float_range_err & mode_r[`CSIF_M_IFP] & ~sup;
    ev[`CSIF_F_ORE]  = operand_req & ~op_in & mode_r[`CSIF_M_IOR] & ~sup;
    ev[`CSIF_F_PRE]  = fetch_req & ~fe_in & ~sup;
    ev[`CSIF_F_MEM]  = (corr_mem_err & mode_r[`CSIF_M_ICM]) |
                       (uncorr_mem_err & mode_r[`CSIF_M_IUM]);
    ev[`CSIF_F_IOI]  = channel_done & ~sup;
    ev[`CSIF_F_EEX]  = error_exit_exec & ~sup;
    ev[`CSIF_F_NEX]  = normal_exit_exec & ~sup & ~supervisor_interrupt_mode;
  end

  //////////////////////////////////////////////////////////////////////
  // APB decode; zero-wait slave, unmapped addresses answer with error
  // No register needs a wait state, so pready is tied high and the
  // access phase always completes in one cycle.
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  reg  hit;
  always @* begin
    case (paddr)
      `CSIF_OFF_FLAGS, `CSIF_OFF_MODE, `CSIF_OFF_CTRL, `CSIF_OFF_XA,
      `CSIF_OFF_VL, `CSIF_OFF_DBA, `CSIF_OFF_DLA, `CSIF_OFF_IBA,
      `CSIF_OFF_ILA, `CSIF_OFF_STAT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;

  // Flag word: events set, a context load replaces, software write-1 clears.
  // Set wins over any clear in the same cycle.
  // A load replaces the word outright: supervisor code must have cleared
  // the stored copy, otherwise the reload starts the next swap at once.
  always @* begin
    flags_nxt = flags_r;
    if (swap_done) begin
      flags_nxt = load_flags;
    end else if (wr && paddr == `CSIF_OFF_FLAGS) begin
      flags_nxt = flags_r & ~pwdata[`CSIF_NFLAGS-1:0];
    end
    flags_nxt = flags_nxt | ev;
  end

  //////////////////////////////////////////////////////////////////////
  // Swap sequencer: idle -> swapping until the issue logic reports done
  // End of interval is ignored while swapping, so a late one cannot
  // restart a sequence that is already moving context words.
  localparam ST_RUN  = 1'b0;
  localparam ST_SWAP = 1'b1;
  reg state_r;
  reg state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:  if (interval_end || request_interrupt) state_nxt = ST_SWAP;
      ST_SWAP: if (swap_done) state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_RUN;
      swap_active <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      swap_active <= (state_nxt == ST_SWAP);
    end
  end

  // Request raised whenever any flag is set and no swap is under way;
  // after a load that leaves flags set it rises again at once.
  assign request_interrupt = (|flags_r) & (state_r == ST_RUN);

  // Block base is 8-bit field with four zero low bits, inside 4096 words
  assign swap_word_addr = {xa_r, {`CSIF_XA_LOW{1'b0}}};
  assign store_flags    = flags_r;
  assign store_ps       = ps_r;

  //////////////////////////////////////////////////////////////////////
  // Context registers: loaded on swap completion, writable over APB
  // A load wins over an APB write in the same cycle, so software can
  // never leave a freshly loaded context half overwritten.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= {`CSIF_NFLAGS{1'b0}};
      mode_r  <= {`CSIF_NMODE{1'b0}};
      xa_r    <= {`CSIF_XA_W{1'b0}};
      vl_r    <= {`CSIF_VL_W{1'b0}};
      dba_r   <= {`CSIF_AW{1'b0}};
      dla_r   <= `CSIF_RST_DLA;
      iba_r   <= {`CSIF_AW{1'b0}};
      ila_r   <= `CSIF_RST_ILA;
      cl_r    <= {`CSIF_CL_W{1'b0}};
      ps_r    <= {`CSIF_PS_W{1'b0}};
      svl_r   <= 1'b0;
      eam_r   <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      if (swap_done) begin
        mode_r <= load_mode;
        xa_r   <= load_xa;
        vl_r   <= load_vl;
        dba_r  <= load_dba;
        dla_r  <= load_dla;
        iba_r  <= load_iba;
        ila_r  <= load_ila;
        cl_r   <= load_cluster;
        ps_r   <= load_ps;
        svl_r  <= load_svl;
        eam_r  <= load_eam;
      end else if (wr) begin
        case (paddr)
          `CSIF_OFF_MODE: mode_r <= pwdata[`CSIF_NMODE-1:0];
          `CSIF_OFF_CTRL: begin
            svl_r <= pwdata[0];
            eam_r <= pwdata[1];
            cl_r  <= pwdata[4+`CSIF_CL_W-1:4];
            ps_r  <= pwdata[8+`CSIF_PS_W-1:8];
          end
          `CSIF_OFF_XA:  xa_r  <= pwdata[`CSIF_XA_W-1:0];
          `CSIF_OFF_VL:  vl_r  <= pwdata[`CSIF_VL_W-1:0];
          `CSIF_OFF_DBA: dba_r <= pwdata[`CSIF_AW-1:0];
          `CSIF_OFF_DLA: dla_r <= pwdata[`CSIF_AW-1:0];
          `CSIF_OFF_IBA: iba_r <= pwdata[`CSIF_AW-1:0];
          `CSIF_OFF_ILA: ila_r <= pwdata[`CSIF_AW-1:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Field outputs to the datapath
  assign second_vlogic_enable = svl_r;
  assign vector_length        = vl_r;
  assign extended_addressing  = eam_r;
  assign cluster_number       = cl_r;
  // Gate for the shared-register decode; cluster_number picks the set
  // Zero cluster denies every shared and semaphore register
  assign shared_access_ok     = (cl_r != {`CSIF_CL_W{1'b0}});

  //////////////////////////////////////////////////////////////////////
  // Read data registered in the setup cycle so it is stable in access
  // Costs a flop per bit, but keeps prdata free of glitches while the
  // master samples it at the end of the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `CSIF_RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CSIF_OFF_FLAGS: prdata <= {{(32-`CSIF_NFLAGS){1'b0}}, flags_r};
        `CSIF_OFF_MODE:  prdata <= {{(32-`CSIF_NMODE){1'b0}}, mode_r};
        `CSIF_OFF_CTRL:  prdata <= {23'h0, ps_r, 1'b0, cl_r, 2'b00, eam_r, svl_r};
        `CSIF_OFF_XA:    prdata <= {24'h0, xa_r};
        `CSIF_OFF_VL:    prdata <= {25'h0, vl_r};
        `CSIF_OFF_DBA:   prdata <= {8'h0, dba_r};
        `CSIF_OFF_DLA:   prdata <= {8'h0, dla_r};
        `CSIF_OFF_IBA:   prdata <= {8'h0, iba_r};
        `CSIF_OFF_ILA:   prdata <= {8'h0, ila_r};
        `CSIF_OFF_STAT:  prdata <= {28'h0, deadlock, shared_access_ok,
                                    swap_active, request_interrupt};
        default:         prdata <= `CSIF_RST_ZERO;
      endcase
    end
  end

endmodule // csif_unit
`default_nettype wire

// ---- csif_consts.vh ----
// Constants for the context-state and interrupt-flag unit
`ifndef CSIF_CONSTS_VH
`define CSIF_CONSTS_VH
// Flag word bit positions
`define CSIF_F_XCPU      0
`define CSIF_F_DEAD      1
`define CSIF_F_PCLK      2
`define CSIF_F_MASTER_IO_PROCESSOR      3
`define CSIF_F_FPE       4
`define CSIF_F_ORE       5
`define CSIF_F_PRE       6
`define CSIF_F_MEM       7
`define CSIF_F_IOI       8
`define CSIF_F_EEX       9
`define CSIF_F_NEX       10
`define CSIF_NFLAGS      11
// Mode word bit positions
`define CSIF_M_IMM       0
`define CSIF_M_IOR       1
`define CSIF_M_ICM       2
`define CSIF_M_IFP       3
`define CSIF_M_IUM       4
`define CSIF_M_MM        5
`define CSIF_NMODE       6
// Field widths
`define CSIF_AW          24
`define CSIF_XA_W        8
`define CSIF_XA_LOW      4
`define CSIF_VL_W        7
`define CSIF_CL_W        3
`define CSIF_PS_W        1
// APB register offsets
`define CSIF_OFF_FLAGS   12'h000
`define CSIF_OFF_MODE    12'h004
`define CSIF_OFF_CTRL    12'h008
`define CSIF_OFF_XA      12'h00c
`define CSIF_OFF_VL      12'h010
`define CSIF_OFF_DBA     12'h014
`define CSIF_OFF_DLA     12'h018
`define CSIF_OFF_IBA     12'h01c
`define CSIF_OFF_ILA     12'h020
`define CSIF_OFF_STAT    12'h024
// Reset values
`define CSIF_RST_ZERO    32'h0000_0000
`define CSIF_RST_DLA     24'hff_ffff
`define CSIF_RST_ILA     24'hff_ffff
`endif

// ---- csif_bounds.v ----
// Half-open address window check: base <= addr < limit
`timescale 1ns/1ps
`default_nettype none
`include "csif_consts.vh"
module csif_bounds (
  input  wire [`CSIF_AW-1:0] addr,
  input  wire [`CSIF_AW-1:0] base,
  input  wire [`CSIF_AW-1:0] limit,
  output wire                lo_ok,
  output wire                hi_ok,
  output wire                in_range
);
  // Lower bound is inclusive, upper bound exclusive
  assign lo_ok    = (addr >= base);
  assign hi_ok    = (addr < limit);
  assign in_range = lo_ok & hi_ok;
endmodule // csif_bounds
`default_nettype wire

// ---- csif_unit_assertions.sv ----
// Checker on the ports of the context-state and interrupt-flag unit
`timescale 1ns/1ps
`default_nettype none
module csif_unit_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        swap_done,
  input wire logic [10:0] load_flags,
  input wire logic [7:0]  load_xa,
  input wire logic [6:0]  load_vl,
  input wire logic [2:0]  load_cluster,
  input wire logic [0:0]  load_ps,
  input wire logic        load_svl,
  input wire logic        load_eam,
  input wire logic        request_interrupt,
  input wire logic        swap_active,
  input wire logic [11:0] swap_word_addr,
  input wire logic [10:0] store_flags,
  input wire logic [0:0]  store_ps,
  input wire logic        second_vlogic_enable,
  input wire logic [6:0]  vector_length,
  input wire logic        extended_addressing,
  input wire logic [2:0]  cluster_number,
  input wire logic        shared_access_ok
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Context load edge, and the only software path that may drop flags
  wire ld  = swap_active && swap_done;
  wire fwr = psel && penable && pwrite && paddr == 12'h000;
  ////////////////////////////////////////////////////////////////////////////////
  flag_req_a: assert property (
    |store_flags && !swap_active |-> request_interrupt ##1 swap_active)
    else $error("set flag did not start a swap");
  swap_end_a: assert property (ld |=> !swap_active)
    else $error("swap did not end after done");
  swap_hold_a: assert property (swap_active && !swap_done |=> swap_active)
    else $error("swap dropped before done");
  reload_swap_a: assert property (
    ld && |load_flags |=> request_interrupt ##1 swap_active)
    else $error("loaded flags did not swap again");
  ctx_addr_a: assert property (ld |=> swap_word_addr == {$past(load_xa), 4'h0})
    else $error("context word address wrong");
  ctx_fields_a: assert property (
    ld |=> vector_length == $past(load_vl) && second_vlogic_enable == $past(load_svl)
    && extended_addressing == $past(load_eam) && store_ps == $past(load_ps))
    else $error("context fields not loaded");
  cluster_sel_a: assert property (
    ld |=> cluster_number == $past(load_cluster) && shared_access_ok == (|$past(load_cluster)))
    else $error("cluster selection wrong");
  flag_keep_a: assert property (
    !swap_done && !fwr |=> (store_flags & $past(store_flags)) == $past(store_flags))
    else $error("flag cleared on its own");
  // Main scenarios reached
  cover property (ld && |load_flags);
  cover property (request_interrupt);
  cover property (ld && load_cluster == 3'h1);
endmodule // csif_unit_assertions
bind csif_unit csif_unit_assertions csif_unit_assertions_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .swap_done, .load_flags, .load_xa, .load_vl, .load_cluster,
  .load_ps, .load_svl, .load_eam, .request_interrupt, .swap_active, .swap_word_addr,
  .store_flags, .store_ps, .second_vlogic_enable, .vector_length, .extended_addressing,
  .cluster_number, .shared_access_ok);
`default_nettype wire

// ---- csif_peer_model.sv ----
// Far-side model: peer processors of the cluster and the context-block memory
`timescale 1ns/1ps
`default_nettype none
module csif_peer_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        swap_active,
  input  wire logic [3:0]  dly,
  input  wire logic [37:0] ctx,
  input  wire logic [3:0]  hold,
  output logic             swap_done,
  output logic [37:0]      lb,
  output logic [23:0]      lo_b,
  output logic [23:0]      hi_b,
  output logic [3:0]       peer_ts_hold,
  output logic [11:0]      peer_cluster
);
  logic [3:0] cnt_r;
  // Memory ends a swap after dly cycles; >= guards against a hang if dly moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= 4'h0;
      swap_done <= 1'b0;
    end else begin
      swap_done <= swap_active && !swap_done && cnt_r >= dly;
      cnt_r     <= (swap_active && !swap_done) ? cnt_r + 4'h1 : 4'h0;
    end
  end
  // Context words are valid only in the done pulse; otherwise their inverse
  assign lb   = swap_done ? ctx : ~ctx;
  assign lo_b = swap_done ? 24'h000100 : 24'hfffeff;
  assign hi_b = swap_done ? 24'h000200 : 24'hfffdff;
  // Peers 0, 1 and 3 share cluster 1; peer 2 sits apart
  assign peer_cluster = {3'h1, 3'h2, 3'h1, 3'h1};
  assign peer_ts_hold = hold;
endmodule // csif_peer_model
`default_nettype wire

// ---- test_csif_unit.sv ----
// Testbench for the context-state and interrupt-flag unit
`timescale 1ns/1ps
`default_nettype none
module test_csif_unit;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, pcl;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr, req_i, swap_a, swap_d, sa_d = 1'b0, opd_ok, fch_ok, e;
  logic [12:0] ev = 13'h0;
  logic [3:0]  hold = 4'h0, dly = 4'h1, phold;
  logic [23:0] oaddr = 24'h0, faddr = 24'h100, lo_b, hi_b, a;
  logic [37:0] ctx = 38'h0, lb;
  logic [10:0] st_f, fq[$];
  logic [32:0] q[$];
  integer      fail_count = 0, checked = 0, seed = 9259, i;
  csif_unit csif_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xcpu_int(ev[0]), .peer_ts_hold(phold), .peer_cluster(pcl),
    .own_ts_hold(ev[1]), .pclk_count_zero(ev[2]), .master_io_processor(ev[3]),
    .float_range_err(ev[4]), .corr_mem_err(ev[7]), .uncorr_mem_err(ev[11]),
    .channel_done(ev[8]), .error_exit_exec(ev[9]), .normal_exit_exec(ev[10]),
    .operand_req(ev[5]), .operand_addr(oaddr), .fetch_req(ev[6]), .fetch_addr(faddr),
    .interval_end(ev[12]), .swap_done(swap_d), .load_flags(lb[37:27]), .load_mode(lb[26:21]),
    .load_xa(lb[20:13]), .load_vl(lb[12:6]), .load_dba(lo_b), .load_dla(hi_b),
    .load_iba(lo_b), .load_ila(hi_b), .load_cluster(lb[5:3]), .load_ps(lb[2]),
    .load_svl(lb[1]), .load_eam(lb[0]), .request_interrupt(req_i), .swap_active(swap_a),
    .swap_word_addr(), .store_flags(st_f), .store_ps(), .second_vlogic_enable(),
    .vector_length(), .extended_addressing(), .cluster_number(), .shared_access_ok(),
    .operand_ok(opd_ok), .fetch_ok(fch_ok));
  csif_peer_model csif_peer_model_inst (.pclk(pclk), .presetn(presetn), .swap_active(swap_a),
    .dly(dly), .ctx(ctx), .hold(hold), .swap_done(swap_d), .lb(lb), .lo_b(lo_b),
    .hi_b(hi_b), .peer_ts_hold(phold), .peer_cluster(pcl));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; a read notes its expected {error, data} first
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [32:0] ex);
    if (!w) q.push_back(ex);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
  endtask
  // Notes the flag word expected at swap start, picks a memory delay, waits it out
  task automatic swp(input logic [10:0] f);
    fq.push_back(f);
    dly <= 4'($random(seed)) & 4'h7;
    @(posedge pclk iff swap_a);
    @(posedge pclk iff !swap_a);
  endtask
  // Results are matched against the oldest note as they appear
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0)
      chk({pslverr, prdata}, q.pop_front());
    if (swap_a && !sa_d) chk({22'h0, st_f}, {22'h0, fq.pop_front()});
    sa_d <= swap_a;
  end
  // Whole run is a few hundred cycles, far under the 20000-cycle limit
  initial begin
    #(25 * 20000);
    fail_count = fail_count + 1;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h018, 0, 33'h0_00ff_ffff);
    apb(0, 12'h020, 0, 33'h0_00ff_ffff);
    apb(0, 12'h000, 0, 33'h0);
    apb(0, 12'h028, 0, {1'b1, 32'h0});
    d = $random(seed);
    apb(1, 12'h010, d, 0);
    apb(0, 12'h010, 0, {26'h0, d[6:0]});
    apb(1, 12'h00c, d, 0);
    apb(0, 12'h00c, 0, {25'h0, d[7:0]});
    apb(1, 12'h004, d, 0);
    apb(0, 12'h004, 0, {27'h0, d[5:0]});
    $display("test registers done");
    ctx <= {11'h0, 6'h1e, 8'h3c, 7'h40, 3'h1, 1'b1, 1'b1, 1'b0};
    pulse(12);
    swp(11'h0);
    apb(0, 12'h008, 0, 33'h111);
    apb(0, 12'h014, 0, 33'h100);
    apb(0, 12'h018, 0, 33'h200);
    apb(1, 12'h024, 32'hffff_ffff, 0);
    apb(0, 12'h024, 0, 33'h4);
    $display("test context load done");
    for (i = 0; i < 16; i++) begin
      a = (i < 8) ? (i[2] ? 24'h1fe : 24'h0fe) + i[1:0] : 24'h0f0 + (24'($random(seed)) & 24'h1ff);
      e = a >= 24'h100 && a < 24'h200;
      @(posedge pclk);
      oaddr <= a;
      faddr <= a;
      @(posedge pclk);
      chk({31'h0, opd_ok, fch_ok}, {31'h0, e, e});
    end
    $display("test bounds done");
    oaddr <= 24'h200;
    faddr <= 24'h0ff;
    for (i = 0; i < 12; i++) begin
      if (i != 1) begin
        pulse(i);
        swp(i == 11 ? 11'h080 : 11'h1 << i);
      end
    end
    $display("test events done");
    @(posedge pclk);
    ev[1] <= 1'b1;
    hold <= 4'h3;
    repeat (3) @(posedge pclk);
    chk({32'h0, req_i}, 33'h0);
    hold <= 4'hb;
    @(posedge pclk);
    ev[1] <= 1'b0;
    hold <= 4'h0;
    swp(11'h002);
    $display("test deadlock done");
    ctx[26:21] <= 6'h3e;
    pulse(12);
    swp(11'h0);
    pulse(8);
    pulse(9);
    repeat (2) @(posedge pclk);
    chk({32'h0, req_i}, 33'h0);
    pulse(7);
    swp(11'h080);
    $display("test supervisor done");
    ctx[37:21] <= {11'h100, 6'h1e};
    pulse(12);
    swp(11'h0);
    ctx[37:27] <= 11'h0;
    swp(11'h100);
    $display("test reswap done");
    print_verdict();
  end
endmodule // test_csif_unit
`default_nettype wire
